// file: verilog/gil_top.sv
// Pin functions, interrupt latches and serial readback routing.
// Assumes the control interface presents register requests on i_mclk and supplies
// the serial readback bit; pin inputs are asynchronous, event inputs are not.
`timescale 1ns/1ps
`default_nettype none
module gil_top (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Register port
   input wire gil_pkg::gil_req_type i_req,
   output logic [15:0] o_reg_rdata,
   // Readback source and timing tick
   input wire gil_pkg::gil_rb_type i_rb,
   input wire logic i_tick,
   // Internal events: temp ok, mic short, mic detect, pll lock
   input wire logic [3:0] i_event,
   // General-purpose pins
   input wire logic [7:0] i_pin_in,
   output logic [7:0] o_pin_out,
   output logic [7:0] o_pin_oe_n,
   // Control data input pin used for three-wire readback
   output logic o_ctl_in_out,
   output logic o_ctl_in_oe_n,
   // Combined interrupt
   output logic o_irq
);
   import gil_pkg::*;

   logic [15:0] rb_ctrl_q;
   logic [15:0] ctrl2_q;
   logic [15:0] fsel_lo_q;
   logic [15:0] fsel_hi_q;
   logic [15:0] pulls_q;
   logic [15:0] pol_deb_q;
   logic [11:0] mask_q;
   logic [11:0] latch_q;
   logic [11:0] latch_d;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] deb_lvl;
   logic [7:0] pin_drive;
   logic [7:0] pin_val;
   logic [7:0] pin_en;
   logic [7:0] sdo_sel;
   logic [15:0] rdata_d;
   logic [7:0] own1_q;
   logic [7:0] own2_q;
   logic [7:0] irq_sel_vec;

   // Register write and read decode
   wire wr_status = i_req.wr && (i_req.addr == GIL_ADDR_STATUS);
   wire rd_status = i_req.rd && (i_req.addr == GIL_ADDR_STATUS);
   wire [11:0] clr_vec = wr_status ? i_req.wdata[11:0] : 12'h000;
   wire three_wire = rb_ctrl_q[GIL_BIT_THREE_WIRE]; // RULE4
   wire drive_style = rb_ctrl_q[GIL_BIT_DRIVE_STYLE]; // RULE4
   wire tristate = ctrl2_q[GIL_BIT_TRISTATE];
   wire irq_output_invert = ctrl2_q[GIL_BIT_IRQ_OUTPUT_INVERT];
   wire [7:0] polarity = pol_deb_q[7:0];
   wire [7:0] deb_en = pol_deb_q[15:8];
   wire [31:0] fsel = {fsel_hi_q, fsel_lo_q};
   wire irq_raw = |(latch_q & mask_q); // RULE14
   wire irq_pin = irq_raw ^ irq_output_invert; // RULE14

   // Pin input conditioning: pass through two flops, filter, polarity
   wire [7:0] pin_lvl = (deb_en & deb_lvl) | (~deb_en & sync2_q); // RULE6
   // Mask covers the pin now driven and its own drive still in the synchroniser
   wire [7:0] pin_qual = (pin_lvl ^ polarity) & ~(pin_drive | own2_q); // RULE8 RULE5
   wire [11:0] set_vec = {i_event, pin_qual}; // RULE12

   // Per-pin function decode and filter
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pin
         wire [3:0] fn = fsel[gi*4 +: 4];
         wire no_pull = !pulls_q[gi] && !pulls_q[gi+8] && !tristate;
         assign sdo_sel[gi] = no_pull && (fn == GIL_FN_READBACK) && !three_wire; // RULE2
         wire irq_sel = no_pull && (fn == GIL_FN_IRQ); // RULE16
         assign irq_sel_vec[gi] = irq_sel;
         wire lvl_sel = no_pull && (fn == GIL_FN_LOGIC0 || fn == GIL_FN_LOGIC1);
         assign pin_drive[gi] = sdo_sel[gi] || irq_sel || lvl_sel;
         assign pin_val[gi] = sdo_sel[gi] ? i_rb.data : (irq_sel ? irq_pin : (fn == GIL_FN_LOGIC1));
         // Wired-OR readback drives only the one, push-pull readback while active, other functions whenever selected
         assign pin_en[gi] = sdo_sel[gi] ? (i_rb.active && (!drive_style || i_rb.data))
                                         : (irq_sel || lvl_sel); // RULE3
         gil_debounce u_deb (
            .i_mclk(i_mclk),
            .i_reset(i_reset),
            .i_tick(i_tick),
            .i_level(sync2_q[gi]),
            .o_level(deb_lvl[gi])
         );
      end
   endgenerate

   // Three-wire readback on the control data input
   wire ctl_en = three_wire && i_rb.active && (!drive_style || !i_rb.data); // RULE1 RULE3

   // Latch: set wins over clear, level sets again after clear
   assign latch_d = (latch_q & ~clr_vec) | set_vec; // RULE9 RULE11

   // Read data select; reading has no side effect
   always_comb begin
      case (i_req.addr)
         GIL_ADDR_STATUS: rdata_d = {3'h0, irq_raw, latch_q}; // RULE10
         GIL_ADDR_FSEL_LO: rdata_d = fsel_lo_q;
         GIL_ADDR_FSEL_HI: rdata_d = fsel_hi_q;
         GIL_ADDR_PULLS: rdata_d = pulls_q;
         GIL_ADDR_RB_CTRL: rdata_d = rb_ctrl_q;
         GIL_ADDR_CTRL2: rdata_d = ctrl2_q;
         GIL_ADDR_POL_DEB: rdata_d = pol_deb_q;
         GIL_ADDR_MASK: rdata_d = {4'h0, mask_q};
         default: rdata_d = 16'h0000;
      endcase
   end

   // Control registers
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         rb_ctrl_q <= GIL_RST_RB_CTRL;
         ctrl2_q <= GIL_RST_CTRL2;
         fsel_lo_q <= GIL_RST_ZERO;
         fsel_hi_q <= GIL_RST_ZERO;
         pulls_q <= GIL_RST_ZERO;
         pol_deb_q <= GIL_RST_ZERO;
         mask_q <= GIL_RST_MASK;
      end else if (i_req.wr) begin
         case (i_req.addr)
            GIL_ADDR_RB_CTRL: rb_ctrl_q <= i_req.wdata;
            GIL_ADDR_CTRL2: ctrl2_q <= i_req.wdata;
            GIL_ADDR_FSEL_LO: fsel_lo_q <= i_req.wdata;
            GIL_ADDR_FSEL_HI: fsel_hi_q <= i_req.wdata;
            GIL_ADDR_PULLS: pulls_q <= i_req.wdata;
            GIL_ADDR_POL_DEB: pol_deb_q <= i_req.wdata;
            GIL_ADDR_MASK: mask_q <= i_req.wdata[11:0];
            default: mask_q <= mask_q;
         endcase
      end
   end

   // Latches, synchronisers and registered outputs
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         latch_q <= 12'h000;
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
         o_reg_rdata <= 16'h0000;
         o_pin_out <= 8'h00;
         o_pin_oe_n <= 8'hff;
         o_ctl_in_out <= 1'b0;
         o_ctl_in_oe_n <= 1'b1;
         o_irq <= 1'b0;
      end else begin
         latch_q <= latch_d;
         sync1_q <= i_pin_in;
         sync2_q <= sync1_q;
         o_reg_rdata <= i_req.rd ? rdata_d : o_reg_rdata;
         o_pin_out <= pin_val;
         o_pin_oe_n <= ~(pin_en & pin_drive);
         o_ctl_in_out <= i_rb.data;
         o_ctl_in_oe_n <= !ctl_en;
         o_irq <= irq_pin; // RULE14 RULE15
      end
   end

   // Drive history, two deep like the synchroniser, so a pin just released
   // cannot latch, while its debounce is off, the level that it was itself driving a moment ago
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         own1_q <= 8'h00;
         own2_q <= 8'h00;
      end else begin
         own1_q <= ~o_pin_oe_n; // RULE5
         own2_q <= own1_q;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   sequence s_status_read;
      rd_status && !i_req.wr;
   endsequence

   latch_sets_a: assert property (1 |=> ((latch_q & $past(set_vec)) == $past(set_vec))) // RULE11
      else $error("latch did not set on a qualified level");
   latch_holds_a: assert property (1 |=>
      ((latch_q & $past(latch_q & ~clr_vec)) == $past(latch_q & ~clr_vec))) // RULE9
      else $error("latch dropped without a clearing write");
   status_read_a: assert property (s_status_read |=>
      (o_reg_rdata[11:0] == $past(latch_q)) && (latch_q == $past(latch_d))) // RULE10
      else $error("status read returned wrong or changed latches");
   irq_or_a: assert property (1 |=> o_irq == $past(irq_pin)) // RULE14
      else $error("interrupt output not the unmasked OR");
   irq_clear_a: assert property ((latch_q == 12'h000) [*2] |=> o_irq == $past(irq_output_invert)) // RULE15
      else $error("interrupt active with all latches clear");
   input_block_a: assert property ((pin_qual & pin_drive) == 8'h00) // RULE5
      else $error("driven pin fed its own latch");
   three_wire_a: assert property (three_wire && drive_style && i_rb.active && i_rb.data
      |=> o_ctl_in_oe_n) // RULE1
      else $error("open-drain readback drove a one");
   four_wire_a: assert property ((sdo_sel != 8'h00) && !drive_style && i_rb.active
      |=> ((o_pin_out ^ {8{$past(i_rb.data)}}) & $past(sdo_sel)) == 8'h00
          && ((o_pin_oe_n & $past(sdo_sel)) == 8'h00)) // RULE2
      else $error("readback pin not driving the data");

   // Steps for the read-hold and interrupt-pin checks
   sequence s_no_read;
      !i_req.rd;
   endsequence

   sequence s_irq_pin_sel;
      irq_sel_vec != 8'h00;
   endsequence

   rdata_hold_a: assert property (s_no_read |=> $stable(o_reg_rdata)) // RULE10
      else $error("read data changed without a read");
   irq_pin_a: assert property (s_irq_pin_sel |=>
      ((o_pin_out ^ {8{$past(irq_pin)}}) & $past(irq_sel_vec)) == 8'h00) // RULE16
      else $error("interrupt pin not showing the combined flag");
   status_bit_a: assert property (s_status_read |=> o_reg_rdata[12] == $past(irq_raw)) // RULE15
      else $error("status summary bit wrong");
   released_block_a: assert property ((pin_qual & own2_q) == 8'h00) // RULE5
      else $error("released pin fed back its own drive");
endmodule : gil_top
`default_nettype wire

// file: verilog/gil_pkg.sv
// Constants, register map and carrier types for the pin, interrupt latch and readback block.
// Assumes one 10 MHz system clock and a register port driven by the control interface.
// How it works
// (RULE1) Three-wire select 1 readback uses control-in pin
// (RULE2) Pin outputs readback on 0110, no pulls
// (RULE3) Drive-style bit picks push-pull or open-drain/wired-OR
// (RULE4) Mode bit 15, drive-style bit 14
// (RULE5) Pin driving as output blocks its input
// (RULE6) Per-pin debounce enable selects filtered input
// (RULE7) Debounce advances only on timing ticks
// (RULE8) Polarity 0 high triggers, 1 low triggers
// (RULE9) Latch holds until software writes one
// (RULE10) Status readable anytime, reading never alters
// (RULE11) Level detection re-sets latch after clear
// (RULE12) Internal events latched like pin inputs
// (RULE13) Software flips polarity per edge before clearing
// (RULE14) Interrupt is OR of unmasked latches, invertible
// (RULE15) Interrupt clears only when all latches zero; the code clears it once all unmasked latches are zero
// (RULE16) Pin outputs interrupt on 0111, no pulls
// (RULE17) Debounce passes level after fixed stable ticks
package gil_pkg;
   // Register indices on the control interface
   localparam logic [6:0] GIL_ADDR_STATUS = 7'h12;
   localparam logic [6:0] GIL_ADDR_FSEL_LO = 7'h13;
   localparam logic [6:0] GIL_ADDR_FSEL_HI = 7'h14;
   localparam logic [6:0] GIL_ADDR_PULLS = 7'h15;
   localparam logic [6:0] GIL_ADDR_RB_CTRL = 7'h16;
   localparam logic [6:0] GIL_ADDR_CTRL2 = 7'h17;
   localparam logic [6:0] GIL_ADDR_POL_DEB = 7'h18;
   localparam logic [6:0] GIL_ADDR_MASK = 7'h19;
   // Field positions
   localparam int GIL_BIT_THREE_WIRE = 15;
   localparam int GIL_BIT_DRIVE_STYLE = 14;
   localparam int GIL_BIT_IRQ_OUTPUT_INVERT = 12;
   localparam int GIL_BIT_TRISTATE = 13;
   localparam int GIL_BIT_IRQ_STATUS = 12;
   // Values after reset
   localparam logic [15:0] GIL_RST_RB_CTRL = 16'h8000;
   localparam logic [15:0] GIL_RST_CTRL2 = 16'h0000;
   localparam logic [15:0] GIL_RST_ZERO = 16'h0000;
   localparam logic [11:0] GIL_RST_MASK = 12'hfff;
   // Pin function codes
   localparam logic [3:0] GIL_FN_LOGIC0 = 4'h2;
   localparam logic [3:0] GIL_FN_LOGIC1 = 4'h3;
   localparam logic [3:0] GIL_FN_READBACK = 4'h6;
   localparam logic [3:0] GIL_FN_IRQ = 4'h7;
   // Debounce stable count in timing ticks
   localparam logic [3:0] GIL_DEB_TICKS = 4'h4;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [15:0] wdata;
   } gil_req_type;

   typedef struct packed {
      logic active;
      logic data;
   } gil_rb_type;
endpackage : gil_pkg

// file: verilog/gil_debounce.sv
// Debounce filter for one pin input.
// Assumes the level is already synchronised and the tick is a one-cycle pulse on i_mclk.
`timescale 1ns/1ps
`default_nettype none
module gil_debounce (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Filter
   input wire logic i_tick,
   input wire logic i_level,
   output logic o_level
);
   import gil_pkg::*;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic out_q;
   logic out_d;
   wire differs = i_level != out_q;
   wire done = i_tick && (cnt_q == GIL_DEB_TICKS - 4'h1);

   // Count ticks of stable new level, restart on any bounce
   always_comb begin
      cnt_d = cnt_q;
      out_d = out_q;
      if (!differs) begin
         cnt_d = 4'h0;
      end else if (done) begin // RULE17
         out_d = i_level;
         cnt_d = 4'h0;
      end else if (i_tick) begin // RULE7
         cnt_d = cnt_q + 4'h1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         cnt_q <= 4'h0;
         out_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign o_level = out_q;
endmodule : gil_debounce
`default_nettype wire

// file: tb/gil_pin_model.sv
// Pin-side model: external sources that sit on the general-purpose pins.
// Assumes the bench sets the level that each outside source would drive.
`timescale 1ns/1ps
`default_nettype none
module gil_pin_model (
   // Levels offered by outside sources
   input wire logic [7:0] i_src,
   // Design drive of each pin
   input wire logic [7:0] i_pin_out,
   input wire logic [7:0] i_pin_oe_n,
   // Resolved pin level
   output logic [7:0] o_level
);
   // A pin the design drives shows its value, otherwise the source level
   assign o_level = (i_pin_oe_n & i_src) | (~i_pin_oe_n & i_pin_out);
endmodule : gil_pin_model
`default_nettype wire

// file: tb/test_gil_top.sv
// Self-checking bench for the pin, interrupt latch and readback block.
// Assumes gil_pkg and the design are compiled first; one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_gil_top;
   import gil_pkg::*;
   logic i_mclk = 0, i_reset = 1, i_tick = 0, tw, st, d;
   gil_req_type i_req = '0;
   gil_rb_type i_rb = '0;
   logic [3:0] i_event = '0;
   logic [7:0] src = '0, pin_lvl, o_pin_out, o_pin_oe_n, pol, lvl;
   logic [15:0] o_reg_rdata, exp_q[$];
   logic o_ctl_in_out, o_ctl_in_oe_n, o_irq;
   int error_cnt = 0, comparisons = 0;
   integer seed = 32'h19cf75d6;
   gil_top i_gil_top (.i_mclk(i_mclk), .i_reset(i_reset), .i_req(i_req),
      .o_reg_rdata(o_reg_rdata), .i_rb(i_rb), .i_tick(i_tick), .i_event(i_event),
      .i_pin_in(pin_lvl), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
      .o_ctl_in_out(o_ctl_in_out), .o_ctl_in_oe_n(o_ctl_in_oe_n), .o_irq(o_irq));
   gil_pin_model i_gil_pin_model (.i_src(src), .i_pin_out(o_pin_out),
      .i_pin_oe_n(o_pin_oe_n), .o_level(pin_lvl));
   // Clock
   always #50 i_mclk = ~i_mclk;
   task automatic wrap_up();
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmp_reg();
      chk(o_reg_rdata, exp_q.pop_front());
   endtask : cmp_reg
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge i_mclk);
         #10;
         i_req = '0;
         i_tick = 0;
      end
   endtask : cyc
   // Hold the timing tick high across n edges, then drop it
   task automatic ticks(input int n);
      @(posedge i_mclk);
      #10;
      i_req = '0;
      i_tick = 1;
      repeat (n) @(posedge i_mclk);
      #10;
      i_tick = 0;
   endtask : ticks
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      @(posedge i_mclk);
      #10;
      i_req = {1'b1, 1'b0, a, v};
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      @(posedge i_mclk);
      #10;
      i_req = {1'b0, 1'b1, a, 16'h0000};
      exp_q.push_back(e);
   endtask : rd
   function automatic logic [15:0] stat(input logic [11:0] l);
      return {3'b000, |l, l};
   endfunction : stat
   // Watcher: a read taken at an edge is judged against the oldest note
   always @(posedge i_mclk) begin
      #1;
      if (i_req.rd === 1'b1)
         cmp_reg();
   end
   // Watchdog
   initial begin
      #2000000;
      error_cnt++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge i_mclk);
      #10;
      i_reset = 0;
      rd(GIL_ADDR_RB_CTRL, GIL_RST_RB_CTRL);
      rd(GIL_ADDR_MASK, {4'h0, GIL_RST_MASK});
      wr(7'h40, 16'hffff);
      rd(7'h40, 16'h0000);
      // Random levels against random polarity, hold, re-set and clear
      repeat (6) begin
         {pol, lvl} = 16'($random(seed));
         wr(GIL_ADDR_POL_DEB, {8'h00, pol});
         src = lvl;
         cyc(4);
         wr(GIL_ADDR_STATUS, 16'h0fff);
         cyc(1);
         rd(GIL_ADDR_STATUS, stat({4'h0, lvl ^ pol}));
         src = pol;
         cyc(4);
         rd(GIL_ADDR_STATUS, stat({4'h0, lvl ^ pol}));
         rd(GIL_ADDR_STATUS, stat({4'h0, lvl ^ pol}));
         cyc(1);
         chk(16'(o_irq), 16'(|(lvl ^ pol)));
         wr(GIL_ADDR_STATUS, 16'h0fff);
         cyc(2);
         rd(GIL_ADDR_STATUS, 16'h0000);
      end
      // Internal events, read-only summary bit, mask and invert
      i_event = 4'($random(seed)) | 4'h1;
      cyc(3);
      wr(GIL_ADDR_STATUS, 16'h1000);
      cyc(1);
      rd(GIL_ADDR_STATUS, stat({i_event, 8'h00}));
      chk(16'(o_irq), 16'h0001);
      wr(GIL_ADDR_MASK, 16'h0000);
      cyc(2);
      chk(16'(o_irq), 16'h0000);
      wr(GIL_ADDR_CTRL2, 16'h1000);
      cyc(2);
      chk(16'(o_irq), 16'h0001);
      i_event = 4'h0;
      src = 8'h00;
      wr(GIL_ADDR_CTRL2, 16'h0000);
      wr(GIL_ADDR_MASK, 16'h0fff);
      wr(GIL_ADDR_POL_DEB, 16'h0000);
      wr(GIL_ADDR_STATUS, 16'h0fff);
      // Pin 0 drives 1, pin 1 carries the interrupt, pin 2 readback
      wr(GIL_ADDR_FSEL_LO, 16'h0673);
      cyc(4);
      rd(GIL_ADDR_STATUS, 16'h0000);
      chk(16'({o_pin_oe_n[1:0], o_pin_out[1:0]}), 16'h0001);
      wr(GIL_ADDR_PULLS, 16'h0001);
      wr(GIL_ADDR_CTRL2, 16'h2000);
      cyc(2);
      chk(16'(o_pin_oe_n[1:0]), 16'h0003);
      wr(GIL_ADDR_CTRL2, 16'h0000);
      wr(GIL_ADDR_PULLS, 16'h0000);
      // Every readback mode, drive style and data bit
      for (int k = 0; k < 8; k++) begin
         {tw, st, d} = 3'(k);
         wr(GIL_ADDR_RB_CTRL, {tw, st, 14'h0000});
         i_rb = {1'b1, d};
         cyc(2);
         rd(GIL_ADDR_RB_CTRL, {tw, st, 14'h0000});
         cyc(1);
         chk(16'({o_ctl_in_oe_n, o_pin_oe_n[2]}), tw ? {st & d, 1'b1} : {1'b1, st & ~d});
         chk(16'(tw ? o_ctl_in_out : o_pin_out[2]), 16'(d));
      end
      i_rb = '0;
      // Debounce: no movement without ticks, pass after the fourth tick
      wr(GIL_ADDR_POL_DEB, 16'h1000);
      src = 8'h10;
      cyc(10);
      rd(GIL_ADDR_STATUS, 16'h0000);
      ticks(3);
      cyc(3);
      rd(GIL_ADDR_STATUS, 16'h0000);
      ticks(1);
      cyc(3);
      rd(GIL_ADDR_STATUS, stat(12'h010));
      // Software edge detect: flip polarity, then clear, no re-set
      wr(GIL_ADDR_POL_DEB, 16'h1010);
      wr(GIL_ADDR_STATUS, 16'h0fff);
      cyc(1);
      rd(GIL_ADDR_STATUS, 16'h0000);
      cyc(2);
      wrap_up();
   end
endmodule : test_gil_top
`default_nettype wire
